//--- hw/flash_pkg.sv
// Shared constants for the serial flash link: opcodes, register fields,
// dummy-cycle selection and the self-timed write time.
// Assumes every end runs on a 50 MHz CLK.
package flash_pkg;

   typedef logic [7:0] byte_t;

   localparam int CLK_MHZ = 50;

   // ****************************************
   // Opcodes
   // ****************************************
   localparam byte_t OP_READ = 8'h03;
   localparam byte_t OP_FAST = 8'h0b;
   localparam byte_t OP_DOUT = 8'h3b;
   localparam byte_t OP_DIO = 8'hbb;
   localparam byte_t OP_WR_EN = 8'h06;
   localparam byte_t OP_SR_WR = 8'h01;
   localparam byte_t OP_RDSR = 8'h05;
   localparam byte_t OP_RDCR = 8'h15;
   localparam byte_t OP_PP = 8'h02;

   // ****************************************
   // Register fields and reset values
   // ****************************************
   localparam int SR_BUSY = 0;
   localparam int SR_LATCH = 1;
   localparam int SR_BP_LO = 2;
   localparam int SR_QE = 6;
   localparam int SR_WDIS = 7;
   localparam int CR_TB = 3;
   localparam int CR_DUM_LO = 6;
   localparam byte_t CR_RESET = 8'h07;

   // ****************************************
   // Dummy counts and timing
   // ****************************************
   localparam logic [3:0] DUM_4 = 4'h4;
   localparam logic [3:0] DUM_6 = 4'h6;
   localparam logic [3:0] DUM_8 = 4'h8;
   localparam logic [3:0] DUM_10 = 4'ha;
   localparam int STATUS_WRITE_CYCLE_TIME_NS = 2000;
   localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_CYCLE_TIME_NS * CLK_MHZ) / 1000;

   // Dummy clocks from the two-bit code; dual-address read differs only at code 00
   function automatic logic [3:0] dummy_clocks(input logic [1:0] code, input logic dual_addr);
      unique case (code)
         2'b00: dummy_clocks = dual_addr ? DUM_4 : DUM_8;
         2'b01: dummy_clocks = DUM_6;
         2'b10: dummy_clocks = DUM_8;
         2'b11: dummy_clocks = DUM_10;
      endcase
   endfunction : dummy_clocks

   // Upper nibble the complement of the lower keeps enhance mode alive
   function automatic logic mode_keeps(input byte_t m);
      mode_keeps = (m[7:4] == ~m[3:0]);
   endfunction : mode_keeps

endpackage : flash_pkg

//--- hw/flash_link_if.sv
// Serial flash link between host controller and flash device.
// Each end gives drive value and active-low enable per data line;
// an undriven line floats high as with a pull-up.
`timescale 1ns/100ps
interface flash_link_if;
   logic cs_n;
   logic sclk;
   logic h_io0_o;
   logic h_io0_oe_n;
   logic h_io1_o;
   logic h_io1_oe_n;
   logic d_io0_o;
   logic d_io0_oe_n;
   logic d_io1_o;
   logic d_io1_oe_n;
   logic io_line_zero;
   logic io_line_one;

   // Wire level: host first, then device, else pulled high
   assign io_line_zero = !h_io0_oe_n ? h_io0_o : (!d_io0_oe_n ? d_io0_o : 1'b1);
   assign io_line_one = !h_io1_oe_n ? h_io1_o : (!d_io1_oe_n ? d_io1_o : 1'b1);

   modport dev (
      input cs_n, sclk, io_line_zero, io_line_one,
      output d_io0_o, d_io0_oe_n, d_io1_o, d_io1_oe_n
   );

   modport host (
      output cs_n, sclk, h_io0_o, h_io0_oe_n, h_io1_o, h_io1_oe_n,
      input io_line_zero, io_line_one
   );
endinterface : flash_link_if

//--- hw/flash_dev.sv
// Serial flash device end: read family, status write, page program.
// Link pins arrive from another clock domain and are synchronised;
// the serial clock must stay at least 4 CLK cycles in each half.
`timescale 1ns/100ps
module flash_dev #(
   parameter int MEM_AW = 10
) (
   input wire logic CLK,
   input wire logic RESET,
   flash_link_if.dev LINK,
   output logic BUSY,
   output logic WRITE_ENABLED,
   output flash_pkg::byte_t STATUS
);
   import flash_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPC = 3'b001,
      ST_ADDR = 3'b010,
      ST_DUMMY = 3'b011,
      ST_DATA = 3'b100,
      ST_WDATA = 3'b101,
      ST_IGN = 3'b110
   } dst_e;

   typedef struct packed {
      logic [2:0] sclk_q;
      logic [2:0] cs_q;
      logic [1:0] io0_q;
      logic [1:0] io1_q;
      dst_e st;
      byte_t op;
      logic [23:0] sh;
      logic [5:0] cnt;
      logic [3:0] dum;
      logic [MEM_AW-1:0] addr;
      byte_t osh;
      logic [2:0] ocnt;
      logic [1:0] oe;
      logic [1:0] o;
      logic wr_dis;
      logic [3:0] bp;
      logic latch;
      logic busy;
      logic [7:0] tmr;
      byte_t cfg;
      logic enh;
      byte_t mode;
      logic pgm;
   } dev_s;

   localparam dev_s RST = '{cs_q: 3'b111, cfg: CR_RESET, st: ST_IDLE, default: '0};
   localparam logic [7:0] TW_LAST = 8'(STATUS_WRITE_CYCLES - 1);

   dev_s r;
   dev_s n;
   byte_t mem [0:(1 << MEM_AW) - 1];

   logic rise;
   logic fall;
   logic cs_hi;
   logic cs_rise;
   logic cs_fall;
   logic io0;
   logic io1;
   logic dual;
   logic two;
   logic mem_we;
   logic [23:0] sh_in;
   byte_t rd_byte;
   byte_t src;
   byte_t nb;
   byte_t stat;
   byte_t wr;

   // Protected window: level times one sixteenth, from top or bottom
   function automatic logic prot(input logic [MEM_AW-1:0] a, input logic [3:0] bp,
                                 input logic tb);
      logic [MEM_AW:0] lim;
      logic [MEM_AW:0] top;
      lim = (MEM_AW + 1)'(bp) << (MEM_AW - 4);
      top = (MEM_AW + 1)'(1) << MEM_AW;
      if (tb) begin
         prot = ({1'b0, a} < lim);
      end else begin
         prot = ({1'b0, a} >= top - lim);
      end
   endfunction : prot

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      n = r;
      mem_we = 1'b0;
      // Three flops on clock and select, two on data; edges come from the second and third
      n.sclk_q = {r.sclk_q[1:0], LINK.sclk};
      n.cs_q = {r.cs_q[1:0], LINK.cs_n};
      n.io0_q = {r.io0_q[0], LINK.io_line_zero};
      n.io1_q = {r.io1_q[0], LINK.io_line_one};
      rise = r.sclk_q[1] & ~r.sclk_q[2];
      fall = ~r.sclk_q[1] & r.sclk_q[2];
      cs_hi = r.cs_q[1];
      cs_rise = r.cs_q[1] & ~r.cs_q[2];
      cs_fall = ~r.cs_q[1] & r.cs_q[2];
      io0 = r.io0_q[1];
      io1 = r.io1_q[1];
      dual = (r.op == OP_DIO);
      two = dual || (r.op == OP_DOUT);
      // Higher line carries the higher bit of each pair
      sh_in = dual ? {r.sh[21:0], io1, io0} : {r.sh[22:0], io0};
      stat = {r.wr_dis, 1'b1, r.bp, r.latch, r.busy};
      rd_byte = mem[r.addr];
      wr = sh_in[7:0];
      src = rd_byte;
      nb = 8'h00;

      // Self-timed cycle; completion drops busy and the latch together
      if (r.busy) begin
         if (r.tmr == 8'h00) begin
            n.busy = 1'b0;
            n.latch = 1'b0;
         end else begin
            n.tmr = r.tmr - 8'h01;
         end
      end

      if (cs_hi) begin
         n.st = ST_IDLE;
         n.oe = 2'b00;
      end

      // Deselect ends a write; a status write is accepted only after exactly 8 or 16 bits
      if (cs_rise && r.st == ST_WDATA) begin
         if (r.op == OP_SR_WR && (r.cnt == 6'd8 || r.cnt == 6'd16)) begin
            nb = (r.cnt == 6'd8) ? r.sh[7:0] : r.sh[15:8];
            n.wr_dis = nb[SR_WDIS];
            n.bp = nb[SR_BP_LO +: 4];
            if (r.cnt == 6'd16) begin
               // Top/bottom select can only be set, never cleared
               n.cfg = {r.sh[7:6], 2'b00, r.cfg[CR_TB] | r.sh[CR_TB], r.sh[2:0]};
            end
            n.busy = 1'b1;
            n.tmr = TW_LAST;
         end else if (r.op == OP_PP) begin
            n.busy = r.pgm;
            n.tmr = TW_LAST;
            n.latch = r.pgm; // Refused program clears the latch at once
         end
      end

      if (cs_fall) begin
         n.cnt = 6'd0;
         n.ocnt = 3'd0;
         n.pgm = 1'b0;
         n.op = 8'h00;
         n.st = ST_OPC;
         if (r.enh) begin
            // Enhance mode: first clocks are address, opcode is implied
            n.op = OP_DIO;
            n.st = r.busy ? ST_IGN : ST_ADDR;
         end
      end else if (!cs_hi && rise) begin
         // Everything from the host is taken on rising clock edges
         unique case (r.st)
            ST_OPC: begin
               n.sh = sh_in;
               n.cnt = r.cnt + 6'd1;
               if (r.cnt == 6'd7) begin
                  n.op = sh_in[7:0];
                  n.cnt = 6'd0;
                  case (sh_in[7:0])
                     OP_READ: n.st = ST_ADDR;
                     OP_FAST, OP_DOUT, OP_DIO: n.st = r.busy ? ST_IGN : ST_ADDR;
                     OP_PP: n.st = (r.busy || !r.latch) ? ST_IGN : ST_ADDR;
                     OP_SR_WR: n.st = (r.busy || !r.latch) ? ST_IGN : ST_WDATA;
                     OP_RDSR, OP_RDCR: n.st = ST_DATA;
                     OP_WR_EN: begin
                        n.st = ST_IGN;
                        n.latch = r.latch | ~r.busy;
                     end
                     default: n.st = ST_IGN;
                  endcase
               end
            end
            ST_ADDR: begin
               n.sh = sh_in;
               n.cnt = r.cnt + (dual ? 6'd2 : 6'd1);
               if (n.cnt == 6'd24) begin
                  n.addr = sh_in[MEM_AW-1:0];
                  n.cnt = 6'd0;
                  n.dum = dummy_clocks(r.cfg[CR_DUM_LO +: 2], dual);
                  if (r.op == OP_READ) begin
                     n.st = ST_DATA;
                  end else if (r.op == OP_PP) begin
                     n.st = ST_WDATA;
                  end else begin
                     n.st = ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               n.cnt = r.cnt + 6'd1;
               // Dual-address read carries the mode byte in its first four
               if (dual && r.cnt < 6'd4) begin
                  n.mode = {r.mode[5:0], io1, io0};
               end
               if (dual && r.cnt == 6'd3) begin
                  n.enh = mode_keeps({r.mode[5:0], io1, io0});
               end
               if (n.cnt == {2'b00, r.dum}) begin
                  n.st = ST_DATA;
               end
            end
            ST_WDATA: begin
               n.sh = sh_in;
               if (r.cnt != 6'h3f) begin
                  n.cnt = r.cnt + 6'd1;
               end
               if (r.op == OP_PP && r.cnt[2:0] == 3'd7) begin
                  n.addr = r.addr + 1'b1;
                  if (!prot(r.addr, r.bp, r.cfg[CR_TB])) begin
                     mem_we = 1'b1;
                     n.pgm = 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end else if (!cs_hi && fall && r.st == ST_DATA) begin
         // Output shifts on falling edges, one or two bits per clock
         src = (r.op == OP_RDSR) ? stat : ((r.op == OP_RDCR) ? r.cfg : rd_byte);
         nb = (r.ocnt == 3'd0) ? src : r.osh;
         n.o = two ? nb[7:6] : {nb[7], 1'b0};
         n.oe = two ? 2'b11 : 2'b10;
         n.osh = two ? {nb[5:0], 2'b00} : {nb[6:0], 1'b0};
         n.ocnt = r.ocnt + (two ? 3'd2 : 3'd1);
         // Next byte after the last bit; natural overflow wraps to zero
         if (n.ocnt == 3'd0 && r.op != OP_RDSR && r.op != OP_RDCR) begin
            n.addr = r.addr + 1'b1;
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   // Erased array reads all ones; programming only clears bits
   initial begin
      for (int i = 0; i < (1 << MEM_AW); i++) begin
         mem[i] = 8'hff;
      end
   end

   // Array write port; plain always, as the erase-state initial shares the array
   always @(posedge CLK) begin
      if (mem_we) begin
         mem[r.addr] <= rd_byte & wr;
      end
   end

   // Pin and user outputs straight from flops
   assign LINK.d_io0_o = r.o[0];
   assign LINK.d_io0_oe_n = ~r.oe[0];
   assign LINK.d_io1_o = r.o[1];
   assign LINK.d_io1_oe_n = ~r.oe[1];
   assign BUSY = r.busy;
   assign WRITE_ENABLED = r.latch;
   assign STATUS = stat;

endmodule : flash_dev

//--- hw/flash_host.sv
// Host controller end of the serial flash link plus its read FIFO.
// Makes the serial clock by dividing CLK; read bytes drain through
// a FIFO, and a full FIFO pauses the serial clock.
`timescale 1ns/100ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW:0] wp;
      logic [PW:0] rp;
   } fifo_s;

   fifo_s r;
   fifo_s n;
   logic [WIDTH-1:0] mem [0:DEPTH-1];

   // Extra pointer bit tells full from empty; DEPTH is a power of two
   assign in_ready = (r.wp - r.rp) != (PW + 1)'(DEPTH);
   assign out_valid = (r.wp != r.rp);
   assign out_data = mem[r.rp[PW-1:0]];

   always_comb begin
      n = r;
      if (in_valid && in_ready) begin
         n.wp = r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         n.rp = r.rp + 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   always_ff @(posedge CLK) begin
      if (in_valid && in_ready) begin
         mem[r.wp[PW-1:0]] <= in_data;
      end
   end
endmodule : byte_fifo

module flash_host #(
   parameter int HALF = 4,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic CLK,
   input wire logic RESET,
   flash_link_if.host LINK,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input flash_pkg::byte_t CMD_OP,
   input wire logic [23:0] CMD_ADDR,
   input flash_pkg::byte_t CMD_MODE,
   input wire logic [3:0] CMD_DUMMY,
   input wire logic [15:0] CMD_WDATA,
   input wire logic [15:0] CMD_LEN,
   input wire logic CMD_SKIP_OP,
   output logic RD_VALID,
   input wire logic RD_READY,
   output flash_pkg::byte_t RD_DATA
);
   import flash_pkg::*;

   typedef enum logic [1:0] {H_IDLE = 2'b00, H_RUN = 2'b01, H_GAP = 2'b10} hst_e;
   typedef enum logic [1:0] {PH_OP = 2'b00, PH_ADDR = 2'b01, PH_DUM = 2'b10,
                             PH_DATA = 2'b11} ph_e;

   typedef struct packed {
      logic [1:0] io0_q;
      logic [1:0] io1_q;
      hst_e st;
      ph_e ph;
      logic [7:0] div;
      logic sclk;
      logic cs_n;
      byte_t op;
      logic [23:0] addr;
      byte_t mode;
      logic [15:0] wd;
      logic [23:0] tx;
      logic [4:0] cnt;
      logic [3:0] dum;
      logic [15:0] len;
      byte_t rx;
      logic [1:0] o;
      logic [1:0] oe;
      logic push;
   } host_s;

   localparam host_s RST = '{cs_n: 1'b1, st: H_IDLE, ph: PH_OP, default: '0};
   localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
   localparam logic [7:0] GAP_LAST = 8'(2 * HALF - 1);

   host_s r;
   host_s n;
   logic f_in_ready;
   logic rd;
   logic dual;
   logic dd;
   logic has_addr;
   logic step;
   logic [4:0] w;
   byte_t rx_in;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      n = r;
      n.push = 1'b0;
      n.io0_q = {r.io0_q[0], LINK.io_line_zero};
      n.io1_q = {r.io1_q[0], LINK.io_line_one};
      rd = !(r.op == OP_SR_WR || r.op == OP_PP);
      dual = (r.op == OP_DIO);
      dd = dual || (r.op == OP_DOUT);
      has_addr = (r.op == OP_READ) || (r.op == OP_FAST) || (r.op == OP_DOUT)
                 || dual || (r.op == OP_PP);
      w = ((r.ph == PH_ADDR && dual) || (r.ph == PH_DATA && rd && dd)) ? 5'd2 : 5'd1;
      rx_in = (rd && dd) ? {r.rx[5:0], r.io1_q[1], r.io0_q[1]} : {r.rx[6:0], r.io1_q[1]};
      step = 1'b0;
      unique case (r.st)
         H_IDLE: begin
            if (CMD_VALID) begin
               n.op = CMD_OP;
               n.addr = CMD_ADDR;
               n.mode = CMD_MODE;
               n.wd = CMD_WDATA;
               n.dum = CMD_DUMMY;
               n.len = CMD_LEN;
               n.cnt = 5'd0;
               n.div = 8'h00;
               n.cs_n = 1'b0;
               n.st = H_RUN;
               n.ph = CMD_SKIP_OP ? PH_ADDR : PH_OP;
               n.tx = CMD_SKIP_OP ? CMD_ADDR : {CMD_OP, 16'h0000};
            end
         end
         H_RUN: begin
            n.div = r.div + 8'h01;
            if (r.div == HALF_LAST) begin
               n.div = 8'h00;
               if (!r.sclk) begin
                  n.sclk = 1'b1;
               end else if (r.ph == PH_DATA && rd && r.cnt + w == 5'd8 && !f_in_ready) begin
                  n.div = r.div; // FIFO full: hold the clock high
               end else begin
                  n.sclk = 1'b0;
                  step = 1'b1;
               end
            end
         end
         H_GAP: begin
            n.div = r.div + 8'h01;
            if (r.div == GAP_LAST) begin
               n.st = H_IDLE;
            end
         end
         default: n.st = H_IDLE;
      endcase

      // One serial clock done: read input, shift, maybe change phase
      if (step) begin
         n.cnt = r.cnt + w;
         // Mode byte goes out two bits per dummy clock on a dual-address read
         n.tx = (r.ph == PH_DUM && dual) ? r.tx << 2 : r.tx << w;
         if (r.ph == PH_DATA && rd) begin
            n.rx = rx_in;
         end
         if (r.ph == PH_DATA && r.cnt + w == 5'd8) begin
            n.push = rd;
            n.rx = rx_in;
            n.cnt = 5'd0;
            n.len = r.len - 16'h0001;
         end
         if ((r.ph == PH_OP && r.cnt == 5'd7) || (r.ph == PH_ADDR && r.cnt + w == 5'd24)
             || (r.ph == PH_DUM && r.cnt + 5'd1 == {1'b0, r.dum})) begin
            n.cnt = 5'd0;
            n.ph = ph_e'(r.ph + 2'b01);
            if (n.ph == PH_ADDR && !has_addr) begin
               n.ph = PH_DUM;
            end
            if (n.ph == PH_DUM && r.dum == 4'h0) begin
               n.ph = PH_DATA;
            end
            n.tx = (n.ph == PH_ADDR) ? r.addr : ((n.ph == PH_DUM) ? {r.mode, 16'h0000}
                                                 : {r.wd, 8'h00});
         end
         if (n.ph == PH_DATA && n.len == 16'h0000) begin
            n.st = H_GAP;
            n.cs_n = 1'b1;
            n.div = 8'h00;
         end
      end

      // Drive lines from the post-step view; changes fall with the clock
      n.oe = 2'b00;
      n.o = 2'b00;
      if (n.st == H_RUN) begin
         unique case (n.ph)
            PH_OP: begin
               n.oe = 2'b01;
               n.o = {1'b0, n.tx[23]};
            end
            PH_ADDR: begin
               n.oe = dual ? 2'b11 : 2'b01;
               n.o = dual ? n.tx[23:22] : {1'b0, n.tx[23]};
            end
            PH_DUM: begin
               if (dual && n.cnt < 5'd4) begin
                  n.oe = 2'b11;
                  n.o = n.tx[23:22];
               end
            end
            PH_DATA: begin
               if (!rd) begin
                  n.oe = 2'b01;
                  n.o = {1'b0, n.tx[23]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .CLK(CLK),
      .RESET(RESET),
      .in_valid(r.push),
      .in_ready(f_in_ready),
      .in_data(r.rx),
      .out_valid(RD_VALID),
      .out_ready(RD_READY),
      .out_data(RD_DATA)
   );

   assign CMD_READY = (r.st == H_IDLE);
   assign LINK.cs_n = r.cs_n;
   assign LINK.sclk = r.sclk;
   assign LINK.h_io0_o = r.o[0];
   assign LINK.h_io0_oe_n = ~r.oe[0];
   assign LINK.h_io1_o = r.o[1];
   assign LINK.h_io1_oe_n = ~r.oe[1];

endmodule : flash_host

//--- tb/flash_link_asserts.sv
// Link checker beside the joined host and device ends.
// Assumes one CLK and RESET for both ends.
`timescale 1ns/100ps
module flash_link_asserts (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic h_io0_oe_n,
   input wire logic d_io0_o,
   input wire logic d_io0_oe_n,
   input wire logic d_io1_oe_n,
   input wire logic BUSY,
   input wire logic WRITE_ENABLED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   // ************************
   // Link properties
   // ************************
   chk_rel_line0: assert property (cs_n [*5] |-> d_io0_oe_n)
      else $error("line zero driven while deselected");
   chk_rel_line1: assert property (cs_n [*5] |-> d_io1_oe_n)
      else $error("line one driven while deselected");
   chk_no_fight: assert property (!(!h_io0_oe_n && !d_io0_oe_n))
      else $error("both ends drive line zero");
   chk_clk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
      else $error("serial clock runs while deselected");
   // Sync delay lands data changes inside the low phase
   chk_shift_fall: assert property ($changed(d_io0_o) && !d_io0_oe_n && $past(!d_io0_oe_n) |-> !sclk)
      else $error("data changed during high phase");
   chk_busy_len: assert property ($rose(BUSY) |-> ##99 BUSY ##1 !BUSY)
      else $error("busy cycle length wrong");
   chk_busy_start: assert property ($rose(BUSY) |-> cs_n && WRITE_ENABLED)
      else $error("busy began without deselect or latch");
   chk_busy_clear: assert property ($fell(BUSY) |-> !WRITE_ENABLED)
      else $error("latch kept after busy cycle");
   chk_wel_idle: assert property ($rose(WRITE_ENABLED) |-> !BUSY)
      else $error("latch set while busy");
endmodule : flash_link_asserts

//--- tb/serial_flash_read_and_status_write_test.sv
// Bench: host and device ends joined by the link interface.
// Assumes 50 MHz CLK and the opcodes of flash_pkg.
`timescale 1ns/100ps
module serial_flash_read_and_status_write_test;
   import flash_pkg::*;
   logic CLK = 0, RESET = 1, CMD_VALID = 0, CMD_SKIP_OP = 0, RD_READY = 0;
   logic CMD_READY, RD_VALID, BUSY, WRITE_ENABLED;
   byte_t CMD_OP = '0, CMD_MODE = '0, RD_DATA, STATUS;
   logic [23:0] CMD_ADDR = '0;
   logic [15:0] CMD_WDATA = '0, CMD_LEN = '0;
   logic [3:0] CMD_DUMMY = '0;
   int bad_count = 0, checked = 0;
   flash_link_if link ();
   flash_dev flash_dev_i (.CLK(CLK), .RESET(RESET), .LINK(link.dev), .BUSY(BUSY),
      .WRITE_ENABLED(WRITE_ENABLED), .STATUS(STATUS));
   flash_host flash_host_i (.CLK(CLK), .RESET(RESET), .LINK(link.host), .CMD_VALID(CMD_VALID),
      .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_MODE(CMD_MODE),
      .CMD_DUMMY(CMD_DUMMY), .CMD_WDATA(CMD_WDATA), .CMD_LEN(CMD_LEN),
      .CMD_SKIP_OP(CMD_SKIP_OP), .RD_VALID(RD_VALID), .RD_READY(RD_READY), .RD_DATA(RD_DATA));
   flash_link_asserts flash_link_asserts_i (.CLK(CLK), .RESET(RESET), .cs_n(link.cs_n),
      .sclk(link.sclk), .h_io0_oe_n(link.h_io0_oe_n), .d_io0_o(link.d_io0_o),
      .d_io0_oe_n(link.d_io0_oe_n), .d_io1_oe_n(link.d_io1_oe_n), .BUSY(BUSY),
      .WRITE_ENABLED(WRITE_ENABLED));
   // Clock generator
   always #10 CLK = ~CLK;
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input byte_t got, input byte_t exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle;
      do @(negedge CLK); while (CMD_READY !== 1'b1);
   endtask : idle
   // Busy level wait, bounded so a stuck flag cannot hang the run
   task automatic wbusy(input logic v);
      for (int t = 0; t < 400 && BUSY !== v; t++) @(negedge CLK);
   endtask : wbusy
   task automatic cmd(input byte_t op, input logic [23:0] a, input logic [3:0] d,
      input byte_t m, input logic [15:0] w, input logic [15:0] n, input logic s);
      idle();
      {CMD_OP, CMD_ADDR, CMD_DUMMY, CMD_MODE} = {op, a, d, m};
      {CMD_WDATA, CMD_LEN, CMD_SKIP_OP} = {w, n, s};
      CMD_VALID = 1;
      @(negedge CLK);
      CMD_VALID = 0;
   endtask : cmd
   // Read n bytes, oldest first against the top byte of the low n bytes of e
   task automatic rd(input byte_t op, input logic [23:0] a, input logic [3:0] d, input byte_t m,
      input logic s, input int n, input logic [23:0] e);
      cmd(op, a, d, m, '0, 16'(n), s);
      for (int i = n - 1; i >= 0; i--) begin
         for (int t = 0; t < 2000 && RD_VALID !== 1'b1; t++) @(negedge CLK);
         chk((RD_VALID === 1'b1) ? RD_DATA : ~e[8*i +: 8], e[8*i +: 8]);
         RD_READY = 1;
         @(negedge CLK);
         RD_READY = 0;
      end
   endtask : rd
   // Main sequence
   initial begin
      repeat (20) @(negedge CLK);
      RESET = 0;
      chk(STATUS, 8'h40);
      cmd(OP_SR_WR, '0, '0, '0, 16'h08c7, 16'h0002, 0);
      idle();
      chk(STATUS, 8'h40);
      rd(OP_RDCR, '0, '0, '0, 0, 1, 24'h07);
      cmd(OP_WR_EN, '0, '0, '0, '0, '0, 0);
      cmd(OP_PP, 24'h3fe, '0, '0, 16'h5aa5, 16'h0002, 0);
      rd(OP_FAST, 24'h3fe, DUM_8, '0, 0, 1, 24'hff);
      wbusy(0);
      chk(STATUS, 8'h40);
      rd(OP_READ, 24'h3fe, '0, '0, 0, 3, 24'h5aa5ff);
      rd(OP_FAST, 24'h3fe, DUM_8, '0, 0, 2, 24'h5aa5);
      rd(OP_DOUT, 24'h3fe, DUM_8, '0, 0, 2, 24'h5aa5);
      rd(OP_DIO, 24'h3fe, DUM_4, '0, 0, 2, 24'h5aa5);
      cmd(OP_WR_EN, '0, '0, '0, '0, '0, 0);
      cmd(OP_SR_WR, '0, '0, '0, 16'h08c7, 16'h0002, 0);
      wbusy(1);
      chk(STATUS, 8'h4b);
      rd(OP_RDSR, '0, '0, '0, 0, 2, 24'h4b48);
      wbusy(0);
      chk(STATUS, 8'h48);
      rd(OP_RDCR, '0, '0, '0, 0, 1, 24'hc7);
      rd(OP_FAST, 24'h3fe, DUM_10, '0, 0, 2, 24'h5aa5);
      rd(OP_DOUT, 24'h3fe, DUM_10, '0, 0, 2, 24'h5aa5);
      rd(OP_DIO, 24'h3fe, DUM_10, 8'ha5, 0, 2, 24'h5aa5);
      rd(OP_DIO, 24'h3ff, DUM_10, 8'hff, 1, 1, 24'ha5);
      rd(OP_DIO, 24'h3ff, DUM_10, 8'hff, 1, 1, 24'hff);
      cmd(OP_WR_EN, '0, '0, '0, '0, '0, 0);
      cmd(OP_PP, 24'h3fe, '0, '0, 16'h0000, 16'h0001, 0);
      idle();
      chk(STATUS, 8'h48);
      rd(OP_READ, 24'h3fe, '0, '0, 0, 1, 24'h5a);
      conclude();
   end
   // Watchdog against a hung handshake
   initial begin
      #600000;
      bad_count++;
      conclude();
   end
endmodule : serial_flash_read_and_status_write_test
